// ===== hw/mode_sel_pkg.sv
// Constants for the parameter list parser and error recovery page
package mode_sel_pkg;
  localparam logic [7:0] HDR_LEN = 8'h04;
  localparam logic [7:0] BD_LEN = 8'h08;
  localparam logic [7:0] BD_NONE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] HDR_MEDIUM = 3'h1;
  localparam logic [2:0] HDR_BDLEN = 3'h3;
  localparam logic [5:0] PG_VENDOR = 6'h00;
  localparam logic [5:0] PG_ERR_RECOV = 6'h01;
  localparam logic [5:0] PG_DISCONNECT = 6'h02;
  localparam logic [5:0] PG_FORMAT = 6'h03;
  localparam logic [5:0] PG_GEOMETRY = 6'h04;
  localparam logic [5:0] PG_CACHING = 6'h08;
  localparam logic [5:0] PG_CONTROL = 6'h0a;
  localparam logic [5:0] PG_DRIVE_CTL = 6'h32;
  localparam logic [5:0] PG_READ_AHEAD = 6'h38;
  localparam logic [5:0] PG_SENSE_ALL = 6'h3f;
  localparam logic [7:0] ER_PAGE_LEN = 8'h0a;
  // Byte offsets within the error recovery page body (after 2-byte header)
  localparam logic [7:0] ER_FLAGS = 8'h00;
  localparam logic [7:0] ER_READ_RETRY = 8'h01;
  localparam logic [7:0] ER_CORR_SPAN = 8'h02;
  localparam logic [7:0] ER_HEAD_OFS = 8'h03;
  localparam logic [7:0] ER_STROBE_OFS = 8'h04;
  localparam logic [7:0] ER_WRITE_RETRY = 8'h06;
  localparam logic [7:0] ER_TIME_MSB = 8'h08;
  localparam logic [7:0] ER_TIME_LSB = 8'h09;
  // Flag bit positions in the flags byte
  localparam int FB_AUTO_WRITE_REALLOC_EN = 7;
  localparam int FB_AUTO_READ_REALLOC_EN = 6;
  localparam int FB_TB = 5;
  localparam int FB_RC = 4;
  localparam int FB_EEC = 3;
  localparam int FB_PER = 2;
  localparam int FB_DTE = 1;
  localparam int FB_DCR = 0;
  // Flag positions reported as changeable
  localparam logic [7:0] CHANGEABLE_MASK = 8'h3f;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_RETRY_RESET = 8'h0a;
  localparam logic [7:0] CORR_SPAN_RESET = 8'h0b;
  localparam logic [7:0] HEAD_OFS_RESET = 8'h02;
  localparam logic [7:0] STROBE_OFS_RESET = 8'h02;
  localparam logic [7:0] WRITE_RETRY_RESET = 8'h04;
  localparam logic [15:0] TIME_RESET = 16'h0000;
  localparam int NUM_INIT = 8;
  localparam logic [3:0] SK_ILLEGAL_REQ = 4'h5;
  localparam logic [7:0] ASC_INVALID_PARAM = 8'h26;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HEADER = 3'b001,
    ST_BLOCK_DESC = 3'b010,
    ST_PAGE_ID = 3'b011,
    ST_PAGE_LEN = 3'b100,
    ST_PAGE_BODY = 3'b101,
    ST_DONE = 3'b110
  } parse_state_t;
endpackage : mode_sel_pkg

// ===== hw/mode_param_list_error_recovery.sv
// Mode select parameter list parser with error recovery page store
`timescale 1ns/1ps
// What this block does
// - Zero list length moves no data and ends without error.
// - List arrives in data out phase: header, optional descriptor, pages.
// - Header is four bytes: reserved, medium type, reserved, descriptor len.
// - Descriptor length must be zero or eight; anything else invalid.
// - Zero descriptor length means absent descriptor, no error.
// - Descriptor: density, 3-byte block count, reserved, 3-byte length.
// - Block count field is ignored.
// - Each page starts with identifier then length; used to step pages.
// - Page identifiers 00,01,02,03,04,08,0a,32,38 decoded; 3f sense only.
// - Error page: id 01, length 0a, flags, counts, time limit.
// - Savable flag reserved on select, one on sense; flags and retry counts per initiator.
// - Write realloc flag: reallocate only on block-not-found writes.
// - Read realloc flag: reallocate after recovery, report afterwards.
// - Transfer-block flag sends the bad block before terminating.
// - Sense reports the failing block address itself.
// - Non-data error termination withholds the affected block.
// - Continuous read disables retries, correction and related flags.
// - Early correction corrects before retries are used up.
// - Changeable view reports one in transfer, continuous, early, report, stop, no-correction flags.
// - Invalid flag combination: check condition, illegal request.
// - Stop-on-error only allowed together with report-errors.
module mode_param_list_error_recovery (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmd_start,
  input wire logic [7:0] param_list_len,
  input wire logic [2:0] initiator_id,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic [2:0] sense_initiator,
  input wire logic sense_changeable,
  input wire logic [2:0] block_block_len_dummy_unused,
  input wire logic write_block_not_found,
  input wire logic read_error,
  input wire logic read_error_recovered,
  input wire logic [23:0] error_block_addr,
  output logic data_req,
  output logic cmd_done,
  output logic check_condition,
  output logic [3:0] sense_key,
  output logic [7:0] sense_asc,
  output logic [23:0] block_length,
  output logic [7:0] sense_page_flags,
  output logic page_savable_flag,
  output logic auto_write_realloc_en,
  output logic auto_read_realloc_en,
  output logic send_bad_block_flag,
  output logic continuous_read_flag,
  output logic early_correction_flag,
  output logic stop_on_error_flag,
  output logic no_correction_flag,
  output logic report_errors_flag,
  output logic [7:0] read_retry_count,
  output logic [7:0] write_retry_count,
  output logic [7:0] corr_span,
  output logic [7:0] head_offset_count,
  output logic [7:0] strobe_offset_count,
  output logic [15:0] recovery_time_limit,
  output logic do_write_realloc,
  output logic do_read_realloc,
  output logic send_error_block,
  output logic [23:0] sense_block_addr
);
  mode_sel_pkg::parse_state_t state_r;
  logic [7:0] remain_r;
  logic [7:0] pos_r;
  logic [7:0] page_len_r;
  logic [5:0] page_id_r;
  logic bad_r;
  logic [2:0] owner_r;
  logic [7:0] stage_flags_r;
  logic [7:0] stage_rr_r;
  logic [7:0] stage_cs_r;
  logic [7:0] stage_ho_r;
  logic [7:0] stage_so_r;
  logic [7:0] stage_wr_r;
  logic [15:0] stage_tl_r;
  logic stage_valid_r;
  logic [7:0] flags_mem [mode_sel_pkg::NUM_INIT];
  logic [7:0] rr_mem [mode_sel_pkg::NUM_INIT];
  logic [7:0] wr_mem [mode_sel_pkg::NUM_INIT];
  logic [7:0] cs_r;
  logic [7:0] ho_r;
  logic [7:0] so_r;
  logic [15:0] tl_r;
  logic take;
  logic last;
  logic page_known;
  logic [7:0] flags_now;

  assign take = data_valid && data_req;
  assign last = (remain_r == 8'h01);

  always_comb begin
    unique case (page_id_r)
      mode_sel_pkg::PG_VENDOR, mode_sel_pkg::PG_ERR_RECOV,
      mode_sel_pkg::PG_DISCONNECT, mode_sel_pkg::PG_FORMAT,
      mode_sel_pkg::PG_GEOMETRY, mode_sel_pkg::PG_CACHING,
      mode_sel_pkg::PG_CONTROL, mode_sel_pkg::PG_DRIVE_CTL,
      mode_sel_pkg::PG_READ_AHEAD: page_known = 1'b1;
      default: page_known = 1'b0;
    endcase
  end

  // Parser walks the byte stream; remain_r bounds it to the list length
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= mode_sel_pkg::ST_IDLE;
      remain_r <= 8'h00;
      pos_r <= 8'h00;
      page_len_r <= 8'h00;
      page_id_r <= 6'h00;
      bad_r <= 1'b0;
      owner_r <= 3'h0;
      data_req <= 1'b0;
      cmd_done <= 1'b0;
      block_length <= 24'h000000;
      stage_valid_r <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      unique case (state_r)
        mode_sel_pkg::ST_IDLE: begin
          if (cmd_start) begin
            owner_r <= initiator_id;
            bad_r <= 1'b0;
            stage_valid_r <= 1'b0;
            pos_r <= 8'h00;
            remain_r <= param_list_len;
            if (param_list_len == mode_sel_pkg::ZERO_BYTE) begin
              state_r <= mode_sel_pkg::ST_DONE;
            end else begin
              data_req <= 1'b1;
              state_r <= mode_sel_pkg::ST_HEADER;
            end
          end
        end
        mode_sel_pkg::ST_HEADER: begin
          if (take) begin
            pos_r <= pos_r + 8'h01;
            remain_r <= remain_r - 8'h01;
            if (pos_r[2:0] == mode_sel_pkg::HDR_MEDIUM &&
                data_byte != mode_sel_pkg::ZERO_BYTE) begin
              bad_r <= 1'b1;
            end
            if (pos_r[2:0] == mode_sel_pkg::HDR_BDLEN) begin
              pos_r <= 8'h00;
              page_len_r <= data_byte;
              if (data_byte == mode_sel_pkg::BD_LEN) begin
                state_r <= mode_sel_pkg::ST_BLOCK_DESC;
              end else if (data_byte == mode_sel_pkg::BD_NONE) begin
                state_r <= mode_sel_pkg::ST_PAGE_ID;
              end else begin
                bad_r <= 1'b1;
                state_r <= mode_sel_pkg::ST_DONE;
              end
            end
            if (last && pos_r[2:0] != mode_sel_pkg::HDR_BDLEN) begin
              bad_r <= 1'b1;
              state_r <= mode_sel_pkg::ST_DONE;
            end else if (last) begin
              // A descriptor announced but cut off by the list length
              if (data_byte != mode_sel_pkg::BD_NONE) bad_r <= 1'b1;
              state_r <= mode_sel_pkg::ST_DONE;
            end
          end
        end
        mode_sel_pkg::ST_BLOCK_DESC: begin
          if (take) begin
            pos_r <= pos_r + 8'h01;
            remain_r <= remain_r - 8'h01;
            if (pos_r == 8'h00 && data_byte != mode_sel_pkg::ZERO_BYTE) begin
              bad_r <= 1'b1;
            end
            // Bytes 1..3 (block count) and 4 are skipped on purpose
            if (pos_r == 8'h05) block_length[23:16] <= data_byte;
            if (pos_r == 8'h06) block_length[15:8] <= data_byte;
            if (pos_r == 8'h07) begin
              block_length[7:0] <= data_byte;
              state_r <= mode_sel_pkg::ST_PAGE_ID;
            end
            if (last) begin
              if (pos_r != 8'h07) bad_r <= 1'b1;
              state_r <= mode_sel_pkg::ST_DONE;
            end
          end
        end
        mode_sel_pkg::ST_PAGE_ID: begin
          if (take) begin
            remain_r <= remain_r - 8'h01;
            page_id_r <= data_byte[5:0];
            state_r <= last ? mode_sel_pkg::ST_DONE
                            : mode_sel_pkg::ST_PAGE_LEN;
            if (last) bad_r <= 1'b1;
          end
        end
        mode_sel_pkg::ST_PAGE_LEN: begin
          if (take) begin
            remain_r <= remain_r - 8'h01;
            page_len_r <= data_byte;
            pos_r <= 8'h00;
            if (!page_known ||
                (page_id_r == mode_sel_pkg::PG_ERR_RECOV &&
                 data_byte != mode_sel_pkg::ER_PAGE_LEN) ||
                data_byte > remain_r - 8'h01) begin
              bad_r <= 1'b1;
              state_r <= mode_sel_pkg::ST_DONE;
            end else if (data_byte == mode_sel_pkg::ZERO_BYTE) begin
              state_r <= last ? mode_sel_pkg::ST_DONE
                              : mode_sel_pkg::ST_PAGE_ID;
            end else begin
              state_r <= mode_sel_pkg::ST_PAGE_BODY;
            end
          end
        end
        mode_sel_pkg::ST_PAGE_BODY: begin
          if (take) begin
            pos_r <= pos_r + 8'h01;
            remain_r <= remain_r - 8'h01;
            if (page_id_r == mode_sel_pkg::PG_ERR_RECOV) begin
              stage_valid_r <= 1'b1;
            end
            if (pos_r + 8'h01 == page_len_r) begin
              state_r <= last ? mode_sel_pkg::ST_DONE
                              : mode_sel_pkg::ST_PAGE_ID;
            end
          end
        end
        mode_sel_pkg::ST_DONE: begin
          data_req <= 1'b0;
          cmd_done <= 1'b1;
          state_r <= mode_sel_pkg::ST_IDLE;
        end
        default: state_r <= mode_sel_pkg::ST_IDLE;
      endcase
      if (take && last) data_req <= 1'b0;
    end
  end

  // Error page body bytes collect in a staging copy; committed only on success
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage_flags_r <= mode_sel_pkg::FLAGS_RESET;
      stage_rr_r <= mode_sel_pkg::READ_RETRY_RESET;
      stage_cs_r <= mode_sel_pkg::CORR_SPAN_RESET;
      stage_ho_r <= mode_sel_pkg::HEAD_OFS_RESET;
      stage_so_r <= mode_sel_pkg::STROBE_OFS_RESET;
      stage_wr_r <= mode_sel_pkg::WRITE_RETRY_RESET;
      stage_tl_r <= mode_sel_pkg::TIME_RESET;
    end else if (take && state_r == mode_sel_pkg::ST_PAGE_BODY &&
                 page_id_r == mode_sel_pkg::PG_ERR_RECOV) begin
      unique case (pos_r)
        mode_sel_pkg::ER_FLAGS: stage_flags_r <= data_byte;
        mode_sel_pkg::ER_READ_RETRY: stage_rr_r <= data_byte;
        mode_sel_pkg::ER_CORR_SPAN: stage_cs_r <= data_byte;
        mode_sel_pkg::ER_HEAD_OFS: stage_ho_r <= data_byte;
        mode_sel_pkg::ER_STROBE_OFS: stage_so_r <= data_byte;
        mode_sel_pkg::ER_WRITE_RETRY: stage_wr_r <= data_byte;
        mode_sel_pkg::ER_TIME_MSB: stage_tl_r[15:8] <= data_byte;
        mode_sel_pkg::ER_TIME_LSB: stage_tl_r[7:0] <= data_byte;
        default: ;
      endcase
    end
  end

  logic combo_bad;
  // Stop-on-error without report, or early correction with no-correction
  // or stop but without report, are the unusable modes
  assign combo_bad = stage_valid_r && (
    (stage_flags_r[mode_sel_pkg::FB_DTE] &&
     !stage_flags_r[mode_sel_pkg::FB_PER]) ||
    (stage_flags_r[mode_sel_pkg::FB_EEC] &&
     !stage_flags_r[mode_sel_pkg::FB_PER] &&
     (stage_flags_r[mode_sel_pkg::FB_DCR] ||
      stage_flags_r[mode_sel_pkg::FB_DTE])));

  // Status: a failed list leaves every stored page untouched
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      check_condition <= 1'b0;
      sense_key <= 4'h0;
      sense_asc <= 8'h00;
    end else if (cmd_start && state_r == mode_sel_pkg::ST_IDLE) begin
      check_condition <= 1'b0;
      sense_key <= 4'h0;
      sense_asc <= 8'h00;
    end else if (state_r == mode_sel_pkg::ST_DONE && (bad_r || combo_bad)) begin
      check_condition <= 1'b1;
      sense_key <= mode_sel_pkg::SK_ILLEGAL_REQ;
      sense_asc <= mode_sel_pkg::ASC_INVALID_PARAM;
    end
  end

  // One copy of flags and retry counts per initiator
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < mode_sel_pkg::NUM_INIT; i++) begin
        flags_mem[i] <= mode_sel_pkg::FLAGS_RESET;
        rr_mem[i] <= mode_sel_pkg::READ_RETRY_RESET;
        wr_mem[i] <= mode_sel_pkg::WRITE_RETRY_RESET;
      end
      cs_r <= mode_sel_pkg::CORR_SPAN_RESET;
      ho_r <= mode_sel_pkg::HEAD_OFS_RESET;
      so_r <= mode_sel_pkg::STROBE_OFS_RESET;
      tl_r <= mode_sel_pkg::TIME_RESET;
    end else if (state_r == mode_sel_pkg::ST_DONE && stage_valid_r &&
                 !bad_r && !combo_bad) begin
      flags_mem[owner_r] <= stage_flags_r;
      rr_mem[owner_r] <= stage_rr_r;
      wr_mem[owner_r] <= stage_wr_r;
      cs_r <= stage_cs_r;
      ho_r <= stage_ho_r;
      so_r <= stage_so_r;
      tl_r <= stage_tl_r;
    end
  end

  assign flags_now = flags_mem[initiator_id];

  // Effective controls for the active initiator; continuous read overrides
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      auto_write_realloc_en <= 1'b0;
      auto_read_realloc_en <= 1'b0;
      send_bad_block_flag <= 1'b0;
      continuous_read_flag <= 1'b0;
      early_correction_flag <= 1'b0;
      stop_on_error_flag <= 1'b0;
      no_correction_flag <= 1'b0;
      report_errors_flag <= 1'b0;
      read_retry_count <= mode_sel_pkg::READ_RETRY_RESET;
      write_retry_count <= mode_sel_pkg::WRITE_RETRY_RESET;
      corr_span <= mode_sel_pkg::CORR_SPAN_RESET;
      head_offset_count <= mode_sel_pkg::HEAD_OFS_RESET;
      strobe_offset_count <= mode_sel_pkg::STROBE_OFS_RESET;
      recovery_time_limit <= mode_sel_pkg::TIME_RESET;
    end else begin
      auto_write_realloc_en <= flags_now[mode_sel_pkg::FB_AUTO_WRITE_REALLOC_EN];
      auto_read_realloc_en <= flags_now[mode_sel_pkg::FB_AUTO_READ_REALLOC_EN];
      continuous_read_flag <= flags_now[mode_sel_pkg::FB_RC];
      if (flags_now[mode_sel_pkg::FB_RC]) begin
        send_bad_block_flag <= 1'b0;
        early_correction_flag <= 1'b0;
        stop_on_error_flag <= 1'b0;
        no_correction_flag <= 1'b1;
        report_errors_flag <= 1'b0;
        read_retry_count <= 8'h00;
      end else begin
        send_bad_block_flag <= flags_now[mode_sel_pkg::FB_TB];
        early_correction_flag <= flags_now[mode_sel_pkg::FB_EEC];
        stop_on_error_flag <= flags_now[mode_sel_pkg::FB_DTE];
        no_correction_flag <= flags_now[mode_sel_pkg::FB_DCR];
        report_errors_flag <= flags_now[mode_sel_pkg::FB_PER];
        read_retry_count <= rr_mem[initiator_id];
      end
      write_retry_count <= wr_mem[initiator_id];
      corr_span <= cs_r;
      head_offset_count <= ho_r;
      strobe_offset_count <= so_r;
      recovery_time_limit <= tl_r;
    end
  end

  // Sense view of the flags byte, current or changeable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sense_page_flags <= 8'h00;
      page_savable_flag <= 1'b0;
    end else begin
      page_savable_flag <= 1'b1;
      sense_page_flags <= sense_changeable ? mode_sel_pkg::CHANGEABLE_MASK
                                           : flags_mem[sense_initiator];
    end
  end

  // Error handling decisions for the media engine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      do_write_realloc <= 1'b0;
      do_read_realloc <= 1'b0;
      send_error_block <= 1'b0;
      sense_block_addr <= 24'h000000;
    end else begin
      do_write_realloc <= write_block_not_found &&
                          flags_now[mode_sel_pkg::FB_AUTO_WRITE_REALLOC_EN];
      do_read_realloc <= read_error && read_error_recovered &&
                         flags_now[mode_sel_pkg::FB_AUTO_READ_REALLOC_EN];
      // Block-not-found is a non-data error and never sends the block
      send_error_block <= read_error && !write_block_not_found &&
        !flags_now[mode_sel_pkg::FB_RC] && flags_now[mode_sel_pkg::FB_TB] &&
        (!read_error_recovered || flags_now[mode_sel_pkg::FB_DTE]);
      if (read_error || write_block_not_found) begin
        sense_block_addr <= error_block_addr;
      end
    end
  end
endmodule : mode_param_list_error_recovery

// ===== verif/init_host_model.sv
// Initiator side model that streams a parameter list when asked
`timescale 1ns/1ps
module init_host_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic restart,
  input wire logic slow,
  input wire logic data_req,
  output logic data_valid,
  output logic [7:0] data_byte
);
  logic [7:0] buf_mem [0:31];
  logic [5:0] idx_r;
  logic [5:0] idx_nxt;
  logic gap;
  assign idx_nxt = idx_r + {5'h00, data_valid & data_req};
  // Slow mode drops valid for one cycle after every byte taken
  assign gap = slow & data_valid & data_req;
  // Bytes go out in list order, multibyte fields most significant first
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idx_r <= 6'h00;
      data_valid <= 1'b0;
      data_byte <= 8'h00;
    end else if (restart) begin
      idx_r <= 6'h00;
      data_valid <= 1'b0;
      data_byte <= ~data_byte;
    end else begin
      idx_r <= idx_nxt;
      if (data_req && !gap) begin
        data_valid <= 1'b1;
        data_byte <= buf_mem[idx_nxt];
      end else begin
        // Released line toggles so a stale byte is never mistaken for data
        data_valid <= 1'b0;
        data_byte <= ~data_byte;
      end
    end
  end
endmodule : init_host_model

// ===== verif/mode_param_monitor.sv
// Concurrent checks on the parameter list parser ports
`timescale 1ns/1ps
module mode_param_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmd_start,
  input wire logic [7:0] param_list_len,
  input wire logic sense_changeable,
  input wire logic write_block_not_found,
  input wire logic read_error_recovered,
  input wire logic data_req,
  input wire logic cmd_done,
  input wire logic check_condition,
  input wire logic [3:0] sense_key,
  input wire logic [7:0] sense_asc,
  input wire logic [7:0] sense_page_flags,
  input wire logic page_savable_flag,
  input wire logic send_bad_block_flag,
  input wire logic continuous_read_flag,
  input wire logic early_correction_flag,
  input wire logic stop_on_error_flag,
  input wire logic no_correction_flag,
  input wire logic report_errors_flag,
  input wire logic [7:0] read_retry_count,
  input wire logic do_write_realloc,
  input wire logic do_read_realloc
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  zero_len_done_a: assert property (
    cmd_start && param_list_len == 8'h00 && !data_req |->
    !data_req ##1 !data_req ##1 (cmd_done && !check_condition))
    else $error("zero length command misbehaved");
  req_after_start_a: assert property (
    cmd_start && param_list_len != 8'h00 && !data_req |=> data_req)
    else $error("data request did not follow start");
  status_hold_a: assert property (
    check_condition && !cmd_start |=> check_condition)
    else $error("check condition dropped early");
  illegal_sense_a: assert property (
    check_condition |-> sense_key == 4'h5 && sense_asc == 8'h26)
    else $error("wrong sense on check condition");
  savable_set_a: assert property (1'b1 |=> page_savable_flag)
    else $error("savable flag not set");
  changeable_view_a: assert property (
    sense_changeable |=> sense_page_flags == mode_sel_pkg::CHANGEABLE_MASK)
    else $error("changeable view wrong");
  rc_override_a: assert property (
    continuous_read_flag |-> !send_bad_block_flag && !early_correction_flag
    && !stop_on_error_flag && no_correction_flag && read_retry_count == 8'h00)
    else $error("continuous read did not override");
  stop_needs_report_a: assert property (
    stop_on_error_flag |-> report_errors_flag)
    else $error("stop on error without report");
  write_realloc_a: assert property (
    do_write_realloc |-> $past(write_block_not_found))
    else $error("write realloc without cause");
  read_realloc_a: assert property (
    do_read_realloc |-> $past(read_error_recovered))
    else $error("read realloc without recovery");
endmodule : mode_param_monitor
bind mode_param_list_error_recovery mode_param_monitor u_mon (.*);

// ===== verif/mode_param_list_error_recovery_tb.sv
// Self-checking bench for the parameter list parser
`timescale 1ns/1ps
module mode_param_list_error_recovery_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_start = 1'b0;
  logic [7:0] param_list_len = 8'h00;
  logic [2:0] initiator_id = 3'h0;
  logic [2:0] sense_initiator = 3'h0;
  logic [2:0] block_block_len_dummy_unused = 3'h0;
  logic sense_changeable = 1'b0;
  logic write_block_not_found = 1'b0;
  logic read_error = 1'b0;
  logic read_error_recovered = 1'b0;
  logic [23:0] error_block_addr = 24'h000000;
  logic restart = 1'b0;
  logic slow = 1'b0;
  logic data_valid, data_req, cmd_done, check_condition, page_savable_flag;
  logic auto_write_realloc_en, auto_read_realloc_en, send_bad_block_flag;
  logic continuous_read_flag, early_correction_flag, stop_on_error_flag;
  logic no_correction_flag, report_errors_flag, do_write_realloc;
  logic do_read_realloc, send_error_block;
  logic [7:0] data_byte, sense_asc, sense_page_flags, read_retry_count;
  logic [7:0] write_retry_count, corr_span, head_offset_count;
  logic [7:0] strobe_offset_count;
  logic [3:0] sense_key;
  logic [23:0] block_length, sense_block_addr;
  logic [15:0] recovery_time_limit;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 mclk = ~mclk;
  mode_param_list_error_recovery dut (.*);
  init_host_model host (.mclk(mclk), .rstn(rstn), .restart(restart),
    .slow(slow), .data_req(data_req), .data_valid(data_valid),
    .data_byte(data_byte));
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // The whole sequence needs a few thousand cycles at most
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle
  task automatic run(input logic [7:0] len);
    int n;
    @(posedge mclk);
    cmd_start <= 1'b1;
    restart <= 1'b1;
    param_list_len <= len;
    @(posedge mclk);
    cmd_start <= 1'b0;
    restart <= 1'b0;
    #1;
    for (n = 0; n < 300 && cmd_done !== 1'b1; n++) settle(1);
    check(n < 300, 1'b1);
  endtask : run
  task automatic hdr(input logic [7:0] med, input logic [7:0] bdl);
    host.buf_mem[0] = 8'h00;
    host.buf_mem[1] = med;
    host.buf_mem[2] = 8'h00;
    host.buf_mem[3] = bdl;
  endtask : hdr
  task automatic erpage(input int at, input logic [7:0] fl);
    logic [95:0] pg;
    pg = {8'h01, 8'h0a, fl, 72'h330c0100000700_0005};
    for (int i = 0; i < 12; i++) host.buf_mem[at + i] = pg[95 - 8 * i -: 8];
  endtask : erpage
  task automatic t_reset();
    settle(2);
    check(read_retry_count, 8'h0a);
    check({write_retry_count, corr_span}, 16'h040b);
    check({head_offset_count, strobe_offset_count}, 16'h0202);
    check(page_savable_flag, 1'b1);
    run(8'h00);
    check(check_condition, 1'b0);
  endtask : t_reset
  task automatic t_desc();
    logic [63:0] d;
    d = 64'h00123456_00000200;
    hdr(8'h00, 8'h00);
    run(8'h04);
    check(check_condition, 1'b0);
    hdr(8'h00, 8'h08);
    for (int i = 0; i < 8; i++) host.buf_mem[4 + i] = d[63 - 8 * i -: 8];
    run(8'h0c);
    check(check_condition, 1'b0);
    check(block_length, 24'h000200);
    host.buf_mem[4] = 8'h01;
    run(8'h0c);
    check(check_condition, 1'b1);
    check({sense_key, sense_asc}, 12'h526);
    hdr(8'h03, 8'h00);
    run(8'h04);
    check(check_condition, 1'b1);
    hdr(8'h00, 8'h04);
    run(8'h08);
    check(check_condition, 1'b1);
  endtask : t_desc
  task automatic t_modes();
    logic [95:0] fl;
    fl = 96'h00_01_04_05_06_07_08_02_03_09_0a_0b;
    slow <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      hdr(8'h00, 8'h00);
      erpage(4, fl[95 - 8 * i -: 8]);
      run(8'h10);
      check(check_condition, i > 6);
      settle(2);
      if (i < 7) check(sense_page_flags, fl[95 - 8 * i -: 8]);
    end
    check({read_retry_count, write_retry_count}, 16'h3307);
    check({corr_span, head_offset_count}, 16'h0c01);
    check(recovery_time_limit, 16'h0005);
    check(early_correction_flag, 1'b1);
    sense_changeable <= 1'b1;
    settle(2);
    check(sense_page_flags, 8'h3f);
    sense_changeable <= 1'b0;
    initiator_id <= 3'h3;
    settle(2);
    check({read_retry_count, 7'h00, early_correction_flag}, 16'h0a00);
    initiator_id <= 3'h0;
    hdr(8'h00, 8'h00);
    erpage(4, 8'h16);
    run(8'h10);
    settle(2);
    check({continuous_read_flag, no_correction_flag}, 2'h3);
    check({stop_on_error_flag, read_retry_count}, 9'h000);
  endtask : t_modes
  task automatic t_pages();
    logic [71:0] pc;
    pc = 72'h00_02_03_04_08_0a_32_38_05;
    slow <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      hdr(8'h00, 8'h00);
      host.buf_mem[4] = pc[71 - 8 * i -: 8];
      host.buf_mem[5] = 8'h02;
      run(8'h08);
      check(check_condition, i == 8);
    end
    erpage(4, 8'h00);
    run(8'h0a);
    check(check_condition, 1'b1);
  endtask : t_pages
  task automatic t_act(input logic [7:0] fl, input logic on);
    hdr(8'h00, 8'h00);
    erpage(4, fl);
    run(8'h10);
    @(posedge mclk);
    write_block_not_found <= 1'b1;
    @(posedge mclk);
    write_block_not_found <= 1'b0;
    read_error_recovered <= 1'b1;
    read_error <= 1'b1;
    #1;
    check(do_write_realloc, on);
    check({auto_write_realloc_en, auto_read_realloc_en}, {on, on});
    check(send_bad_block_flag, on);
    check(report_errors_flag, on);
    @(posedge mclk);
    read_error_recovered <= 1'b0;
    error_block_addr <= 24'h00abcd;
    #1;
    check(do_read_realloc, on);
    @(posedge mclk);
    read_error <= 1'b0;
    #1;
    check(send_error_block, on);
    if (on) check(sense_block_addr, 24'h00abcd);
  endtask : t_act
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_desc();
    t_modes();
    t_pages();
    t_act(8'he4, 1'b1);
    t_act(8'h00, 1'b0);
    tally_and_finish();
  end
endmodule : mode_param_list_error_recovery_tb
